// >>> shared/mref_pkg.sv
// Behaviour
// - A masked-in condition bit rising from 0 to 1 sets its event bit.
// - Mask bit one enables rise detection; zero leaves that event bit untouched.
// - Host writes the summed bit weights as one integer; device loads it as mask.
// - Each mask bit n weighs two to the n; bit 0 is 1, bit 14 is 16384.
// - Condition bit 0 rises when a reading exceeds the range limits.
// - Bit 1 below lower bound one, bit 3 below bound two, bit 4 above two.
// - Bit 2 flags a reading greater than the limit one setting.
// - Bit 5 rises once a reading has been taken and fully processed.
// - Bit 6 rises when a resistance reading falls below the lower range limit.
// - Bit 7 at two readings buffered, bit 8 at half full, bit 9 when full.
// - Bit 10 rises when an alternating-polarity sequence reading becomes available.
// - Bit 11 rises when the trace-buffer pretrigger event occurs.
// - Bit 12 rises when a noise spike is detected.
// - Bit 13 rises on fixture lid closing, bit 14 on source compliance.
// - Mask bit 9 set makes event bit 9 set when the buffer fills.
package mref_pkg;

  localparam int MREF_W = 16;
  localparam int MREF_USED = 15;
  localparam int MREF_READ_W = 24;
  localparam int MREF_BUF_W = 16;

  localparam int MREF_B_OVER = 0;
  localparam int MREF_B_LOW1 = 1;
  localparam int MREF_B_HIGH1 = 2;
  localparam int MREF_B_LOW2 = 3;
  localparam int MREF_B_HIGH2 = 4;
  localparam int MREF_B_RDY = 5;
  localparam int MREF_B_UNDER = 6;
  localparam int MREF_B_BUF2 = 7;
  localparam int MREF_B_HALF = 8;
  localparam int MREF_B_FULL = 9;
  localparam int MREF_B_SEQ = 10;
  localparam int MREF_B_PRE = 11;
  localparam int MREF_B_SPIKE = 12;
  localparam int MREF_B_LID = 13;
  localparam int MREF_B_COMPL = 14;

  // Decimal weight of each mask bit; bit 15 carries none.
  localparam logic [15:0] MREF_WEIGHT [MREF_W] = '{
    16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0040, 16'h0080,
    16'h0100, 16'h0200, 16'h0400, 16'h0800, 16'h1000, 16'h2000, 16'h4000, 16'h0000
  };

  localparam logic [15:0] MREF_USED_BITS = 16'h7FFF;
  localparam logic [15:0] MREF_MASK_RST = 16'h7FFF;
  localparam logic [15:0] MREF_BUF_AVAIL_MIN = 16'h0002;

  typedef struct packed {
    logic valid;
    logic signed [MREF_READ_W-1:0] value;
  } mref_reading_t;

  typedef struct packed {
    logic signed [MREF_READ_W-1:0] lower_one;
    logic signed [MREF_READ_W-1:0] upper_one;
    logic signed [MREF_READ_W-1:0] lower_two;
    logic signed [MREF_READ_W-1:0] upper_two;
  } mref_limits_t;

  typedef struct packed {
    logic reading_over_range;
    logic new_reading_ready;
    logic reading_under_range;
    logic sequence_reading_ready;
    logic buffer_pretrigger_seen;
    logic noise_spike_flag;
    logic source_compliance_flag;
  } mref_flags_t;

  typedef struct packed {
    logic [MREF_BUF_W-1:0] count;
    logic [MREF_BUF_W-1:0] depth;
  } mref_buf_t;

endpackage

// >>> hdl/mref_edge_cell.sv
`timescale 1ns/1ps
`default_nettype none
module mref_edge_cell (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic cond_in,
  input wire logic mask_in,
  input wire logic clr_in,
  output logic evt_out
);

  logic prev_ff;
  logic evt_ff;
  logic rise;

  assign rise = cond_in & ~prev_ff;
  assign evt_out = evt_ff;

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= cond_in;
    end
  end

  // A rise in the cycle of a clear wins, so no event is lost to a read.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      evt_ff <= 1'b0;
    end else if (rise && mask_in) begin
      evt_ff <= 1'b1;
    end else if (clr_in) begin
      evt_ff <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/mref_filter.sv
`timescale 1ns/1ps
`default_nettype none
module mref_filter (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire mref_pkg::mref_reading_t reading_in,
  input wire mref_pkg::mref_limits_t limits_in,
  input wire mref_pkg::mref_flags_t flags_in,
  input wire mref_pkg::mref_buf_t buf_in,
  input wire logic lid_shut_pin_in,
  input wire logic mask_wr_in,
  input wire logic [15:0] mask_wdata_in,
  input wire logic mask_rd_in,
  input wire logic event_rd_in,
  output logic [15:0] mask_rdata_out,
  output logic mask_rvalid_out,
  output logic [15:0] event_rdata_out,
  output logic event_rvalid_out,
  output logic [15:0] cond_out,
  output logic [15:0] event_out
);
  import mref_pkg::*;

  logic [15:0] mask_ff;
  logic [15:0] nxt_mask;
  logic [15:0] cond_ff;
  logic [15:0] nxt_cond;
  logic [15:0] event_vec;
  logic [3:0] limit_ff;
  logic lid_meta_ff;
  logic lid_sync_ff;
  logic [15:0] mask_rdata_ff;
  logic mask_rvalid_ff;
  logic [15:0] event_rdata_ff;
  logic event_rvalid_ff;
  logic buf_nonzero;
  logic [15:0] buf_half;

  // The lid switch is a raw pin, so it is brought onto the clock first.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      lid_meta_ff <= 1'b0;
      lid_sync_ff <= 1'b0;
    end else begin
      lid_meta_ff <= lid_shut_pin_in;
      lid_sync_ff <= lid_meta_ff;
    end
  end

  // Limit results are held from one reading to the next, since the limit
  // state is a level that only a new reading may change.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      limit_ff <= 4'h0;
    end else if (reading_in.valid) begin
      limit_ff[0] <= reading_in.value < limits_in.lower_one;
      limit_ff[1] <= reading_in.value > limits_in.upper_one;
      limit_ff[2] <= reading_in.value < limits_in.lower_two;
      limit_ff[3] <= reading_in.value > limits_in.upper_two;
    end
  end

  assign buf_nonzero = buf_in.depth != 16'h0000;
  assign buf_half = buf_in.depth >> 1;

  always_comb begin
    nxt_cond = 16'h0000;
    nxt_cond[MREF_B_OVER] = flags_in.reading_over_range;
    nxt_cond[MREF_B_LOW1] = limit_ff[0];
    nxt_cond[MREF_B_HIGH1] = limit_ff[1];
    nxt_cond[MREF_B_LOW2] = limit_ff[2];
    nxt_cond[MREF_B_HIGH2] = limit_ff[3];
    nxt_cond[MREF_B_RDY] = flags_in.new_reading_ready;
    nxt_cond[MREF_B_UNDER] = flags_in.reading_under_range;
    nxt_cond[MREF_B_BUF2] = buf_in.count >= MREF_BUF_AVAIL_MIN;
    nxt_cond[MREF_B_HALF] = buf_nonzero && (buf_in.count >= buf_half);
    nxt_cond[MREF_B_FULL] = buf_nonzero && (buf_in.count >= buf_in.depth);
    nxt_cond[MREF_B_SEQ] = flags_in.sequence_reading_ready;
    nxt_cond[MREF_B_PRE] = flags_in.buffer_pretrigger_seen;
    nxt_cond[MREF_B_SPIKE] = flags_in.noise_spike_flag;
    nxt_cond[MREF_B_LID] = lid_sync_ff;
    nxt_cond[MREF_B_COMPL] = flags_in.source_compliance_flag;
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      cond_ff <= 16'h0000;
    end else begin
      cond_ff <= nxt_cond;
    end
  end

  // The written integer is the sum of the weights, so each weight that is
  // present in it switches its bit on; bit 15 has no weight and stays zero.
  always_comb begin
    nxt_mask = 16'h0000;
    for (int i = 0; i < MREF_W; i++) begin
      nxt_mask[i] = (mask_wdata_in & MREF_WEIGHT[i]) != 16'h0000;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      mask_ff <= MREF_MASK_RST;
    end else if (mask_wr_in) begin
      mask_ff <= nxt_mask;
    end
  end

  // A query in the cycle of a write returns the value before the write.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      mask_rdata_ff <= 16'h0000;
      mask_rvalid_ff <= 1'b0;
    end else begin
      mask_rvalid_ff <= mask_rd_in;
      if (mask_rd_in) begin
        mask_rdata_ff <= mask_ff & MREF_USED_BITS;
      end
    end
  end

  // Reading the event register clears it, as a status summary should.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      event_rdata_ff <= 16'h0000;
      event_rvalid_ff <= 1'b0;
    end else begin
      event_rvalid_ff <= event_rd_in;
      if (event_rd_in) begin
        event_rdata_ff <= event_vec;
      end
    end
  end

  for (genvar g = 0; g < MREF_USED; g++) begin : g_cell
    mref_edge_cell u_cell (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .cond_in(cond_ff[g]),
      .mask_in(mask_ff[g]),
      .clr_in(event_rd_in),
      .evt_out(event_vec[g])
    );
  end
  assign event_vec[15] = 1'b0;

  assign mask_rdata_out = mask_rdata_ff;
  assign mask_rvalid_out = mask_rvalid_ff;
  assign event_rdata_out = event_rdata_ff;
  assign event_rvalid_out = event_rvalid_ff;
  assign cond_out = cond_ff;
  assign event_out = event_vec;

  // Helper state used only by the checks below.
  logic [15:0] cond_q_ff;
  logic [15:0] rise_vec;

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      cond_q_ff <= 16'h0000;
    end else begin
      cond_q_ff <= cond_ff;
    end
  end

  assign rise_vec = cond_ff & ~cond_q_ff;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  rise_sets_event_a: assert property (
    ((rise_vec & mask_ff) != 16'h0000) |=>
      ((event_vec & $past(rise_vec & mask_ff)) == $past(rise_vec & mask_ff)))
  else $error("Masked rising condition did not set its event bit.");

  masked_off_quiet_a: assert property (
    ((event_vec & ~$past(event_vec)) & ~$past(rise_vec & mask_ff)) == 16'h0000)
  else $error("Event bit set without an enabled rising condition.");

  disabled_bit_a: assert property (
    (!mask_ff[MREF_B_RDY] && !event_vec[MREF_B_RDY] && !event_rd_in) |=>
      !event_vec[MREF_B_RDY])
  else $error("Disabled event bit changed.");

  mask_load_a: assert property (
    mask_wr_in |=> (mask_ff == ($past(mask_wdata_in) & MREF_USED_BITS)))
  else $error("Mask not loaded from the written integer.");

  weight_ends_a: assert property (
    (mask_wr_in && mask_wdata_in == 16'h4001) |=> (mask_ff == 16'h4001))
  else $error("Weights of bits 0 and 14 not honoured.");

  bit15_zero_a: assert property (
    !mask_ff[15] && !event_vec[15] && !mask_rdata_out[15])
  else $error("Unused bit 15 is not zero.");

  query_reply_a: assert property (
    mask_rd_in |=> (mask_rvalid_out && mask_rdata_out == $past(mask_ff)))
  else $error("Mask query reply wrong or late.");

  overflow_cond_a: assert property (
    flags_in.reading_over_range |=> cond_ff[MREF_B_OVER])
  else $error("Overflow condition not raised.");

  high_one_a: assert property (
    (reading_in.valid && reading_in.value > limits_in.upper_one) |-> ##2
      cond_ff[MREF_B_HIGH1])
  else $error("Above bound one condition not raised two cycles later.");

  low_two_a: assert property (
    (reading_in.valid && reading_in.value >= limits_in.lower_two) |-> ##2
      !cond_ff[MREF_B_LOW2])
  else $error("Below bound two raised for a reading not below it.");

  ready_cond_a: assert property (
    flags_in.new_reading_ready |=> cond_ff[MREF_B_RDY])
  else $error("New reading condition not raised.");

  under_cond_a: assert property (
    flags_in.reading_under_range |=> cond_ff[MREF_B_UNDER])
  else $error("Underflow condition not raised.");

  buffer_full_a: assert property (
    (buf_nonzero && buf_in.count >= buf_in.depth) |=>
      (cond_ff[MREF_B_FULL] && cond_ff[MREF_B_HALF]))
  else $error("Buffer full condition not raised.");

  buffer_two_a: assert property (
    (buf_in.count < MREF_BUF_AVAIL_MIN) |=> !cond_ff[MREF_B_BUF2])
  else $error("Two-reading condition raised too early.");

  misc_flags_a: assert property (
    (flags_in.sequence_reading_ready && flags_in.buffer_pretrigger_seen) |=>
      (cond_ff[MREF_B_SEQ] && cond_ff[MREF_B_PRE]))
  else $error("Sequence or pretrigger condition missing.");

  spike_cond_a: assert property (
    flags_in.noise_spike_flag |=> cond_ff[MREF_B_SPIKE])
  else $error("Noise spike condition not raised.");

  lid_sync_a: assert property (
    lid_shut_pin_in [*3] |=> cond_ff[MREF_B_LID])
  else $error("Lid closed condition not raised after synchronising.");

  full_event_a: assert property (
    (mask_ff[MREF_B_FULL] && rise_vec[MREF_B_FULL]) |=> event_vec[MREF_B_FULL])
  else $error("Buffer full event not set with its mask bit on.");

  read_clear_a: assert property (
    event_rd_in |=> (event_vec == $past(rise_vec & mask_ff)) &&
      event_rvalid_out && (event_rdata_out == $past(event_vec)))
  else $error("Event read did not report and clear correctly.");

  mask_544_c: cover property (mask_wr_in && mask_wdata_in == 16'h0220);
  full_event_c: cover property ($rose(event_vec[MREF_B_FULL]));
  set_on_clear_c: cover property (event_rd_in && (rise_vec & mask_ff) != 16'h0000);
  lid_event_c: cover property ($rose(event_vec[MREF_B_LID]));

endmodule
`default_nettype wire

// >>> verif/tb_mref_filter.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mref_filter;
  import mref_pkg::*;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  mref_reading_t reading_in = '0;
  mref_limits_t limits_in = '0;
  mref_flags_t flags_in = '0;
  mref_buf_t buf_in = '0;
  logic lid_shut_pin_in = 1'b0;
  logic mask_wr_in = 1'b0;
  logic [15:0] mask_wdata_in = 16'h0000;
  logic mask_rd_in = 1'b0;
  logic event_rd_in = 1'b0;
  logic [15:0] mask_rdata_out, event_rdata_out, cond_out, event_out;
  logic mask_rvalid_out, event_rvalid_out;
  int mismatches = 0;
  int compares = 0;
  logic [31:0] seed = 32'h325094E0;
  logic [15:0] exp_mask = 16'h7FFF;
  logic [15:0] exp_evt = 16'h0000;
  logic [15:0] exp_cond = 16'h0000;
  logic [4:1] lim_bits = 4'h0;

  mref_filter uut (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .reading_in(reading_in), .limits_in(limits_in),
    .flags_in(flags_in), .buf_in(buf_in), .lid_shut_pin_in(lid_shut_pin_in),
    .mask_wr_in(mask_wr_in), .mask_wdata_in(mask_wdata_in), .mask_rd_in(mask_rd_in),
    .event_rd_in(event_rd_in), .mask_rdata_out(mask_rdata_out),
    .mask_rvalid_out(mask_rvalid_out), .event_rdata_out(event_rdata_out),
    .event_rvalid_out(event_rvalid_out), .cond_out(cond_out), .event_out(event_out)
  );

  always #10 mclk_in = ~mclk_in;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [23:0] sx4(input logic [3:0] v);
    return {{20{v[3]}}, v};
  endfunction

  // Expected condition word once every input path has settled.
  function automatic logic [15:0] cond_of(input mref_flags_t f, input mref_buf_t b,
      input logic [4:1] lb, input logic lid);
    logic [15:0] c;
    c = 16'h0000;
    c[0] = f.reading_over_range;
    c[4:1] = lb;
    c[5] = f.new_reading_ready;
    c[6] = f.reading_under_range;
    c[7] = b.count >= 16'h0002;
    c[8] = (b.depth != 16'h0000) && (b.count >= (b.depth >> 1));
    c[9] = (b.depth != 16'h0000) && (b.count >= b.depth);
    c[10] = f.sequence_reading_ready;
    c[11] = f.buffer_pretrigger_seen;
    c[12] = f.noise_spike_flag;
    c[13] = lid;
    c[14] = f.source_compliance_flag;
    return c;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic query_mask();
    @(negedge mclk_in) mask_rd_in = 1'b1;
    @(negedge mclk_in) mask_rd_in = 1'b0;
    chk({15'h0000, mask_rvalid_out}, 16'h0001, "mask rvalid");
    chk(mask_rdata_out, exp_mask, "mask query");
  endtask

  // A query issued with the write must still report the previous mask.
  task automatic write_mask(input logic [15:0] v);
    @(negedge mclk_in);
    mask_wr_in = 1'b1;
    mask_wdata_in = v;
    mask_rd_in = 1'b1;
    @(negedge mclk_in);
    mask_wr_in = 1'b0;
    mask_rd_in = 1'b0;
    chk(mask_rdata_out, exp_mask, "query beside write");
    exp_mask = v & MREF_USED_BITS;
    query_mask();
  endtask

  task automatic read_events();
    @(negedge mclk_in) event_rd_in = 1'b1;
    @(negedge mclk_in) event_rd_in = 1'b0;
    chk({15'h0000, event_rvalid_out}, 16'h0001, "event rvalid");
    chk(event_rdata_out, exp_evt, "event read");
    exp_evt = 16'h0000;
    chk(event_out, 16'h0000, "event cleared");
  endtask

  // Inputs change in one go, then the bench waits past the slowest path (lid pin).
  task automatic step(input logic [31:0] r, input logic rd);
    logic [15:0] nc;
    @(negedge mclk_in);
    flags_in = mref_flags_t'(r[6:0]);
    buf_in.depth = {12'h000, r[11:8]};
    buf_in.count = {12'h000, r[15:12]};
    lid_shut_pin_in = r[16];
    if (rd) begin
      seed = xs(seed);
      reading_in.valid = 1'b1;
      reading_in.value = sx4(seed[3:0]);
      limits_in.lower_one = sx4(seed[7:4]);
      limits_in.upper_one = sx4(seed[11:8]);
      limits_in.lower_two = sx4(seed[15:12]);
      limits_in.upper_two = sx4(seed[19:16]);
      lim_bits = {reading_in.value > limits_in.upper_two, reading_in.value < limits_in.lower_two,
        reading_in.value > limits_in.upper_one, reading_in.value < limits_in.lower_one};
    end
    nc = cond_of(flags_in, buf_in, lim_bits, r[16]);
    exp_evt = exp_evt | (nc & ~exp_cond & exp_mask);
    exp_cond = nc;
    @(negedge mclk_in) reading_in.valid = 1'b0;
    repeat (4) @(negedge mclk_in);
    chk(cond_out, exp_cond, "condition");
    chk(event_out, exp_evt, "event");
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge mclk_in);
    @(negedge mclk_in) nrst_in = 1'b1;
    chk(cond_out, 16'h0000, "cond after reset");
    chk(event_out, 16'h0000, "event after reset");
    query_mask();
    $display("test reset done");
    for (int n = 0; n < 16; n++) begin
      write_mask(16'h0001 << n);
    end
    write_mask(16'hFFFF);
    write_mask(16'h0220);
    $display("test weights done");
    step(32'h0000_8800, 1'b0);
    chk(event_out, 16'h0200, "full only");
    read_events();
    step(32'h0000_0000, 1'b0);
    $display("test buffer full done");
    write_mask(16'h4001);
    step(32'h0000_0040, 1'b0);
    // A condition still high when reset ends counts as a fresh rise.
    @(negedge mclk_in) nrst_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    nrst_in = 1'b1;
    chk(event_out, 16'h0000, "event after mid reset");
    exp_mask = MREF_MASK_RST;
    exp_evt = 16'h0000;
    exp_cond = 16'h0000;
    step(32'h0000_0040, 1'b0);
    read_events();
    step(32'h0000_0000, 1'b0);
    query_mask();
    $display("test mid reset done");
    for (int i = 0; i < 150; i++) begin
      seed = xs(seed);
      if (seed[31:28] == 4'h0) begin
        write_mask(seed[15:0]);
      end
      seed = xs(seed);
      step(seed, seed[31]);
      if (seed[30:29] == 2'b00) begin
        read_events();
      end
    end
    read_events();
    $display("test random done");
    wrap_up();
  end

  // The run needs under 2000 cycles; this allows ten times that.
  initial begin
    #400000;
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
